// file: design/id_page_pkg.sv
// Constants for the identify-device parameter page generator.
// Assumes one 100 MHz clock and a synchronous active-low reset.
package id_page_pkg;

  // ==========================================================
  // Page geometry
  localparam int unsigned PAGE_WORDS = 256;
  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned WORD_W     = 16;

  // ==========================================================
  // Word indices
  localparam logic [7:0] W_GEN_CFG   = 8'h00;
  localparam logic [7:0] W_CYL_DEF   = 8'h01;
  localparam logic [7:0] W_SPEC_CFG  = 8'h02;
  localparam logic [7:0] W_HEAD_DEF  = 8'h03;
  localparam logic [7:0] W_RET5      = 8'h05;
  localparam logic [7:0] W_SPT_DEF   = 8'h06;
  localparam logic [7:0] W_OBS22     = 8'h16;
  localparam logic [7:0] W_MODEL_LO  = 8'h1b;
  localparam logic [7:0] W_MULT_MAX  = 8'h2f;
  localparam logic [7:0] W_CAPAB     = 8'h31;
  localparam logic [7:0] W_CAPAB2    = 8'h32;
  localparam logic [7:0] W_PIO_OLD   = 8'h33;
  localparam logic [7:0] W_VALID     = 8'h35;
  localparam logic [7:0] W_CUR_CYL   = 8'h36;
  localparam logic [7:0] W_CUR_HEAD  = 8'h37;
  localparam logic [7:0] W_CUR_SPT   = 8'h38;
  localparam logic [7:0] W_CUR_CAP_L = 8'h39;
  localparam logic [7:0] W_CUR_CAP_H = 8'h3a;
  localparam logic [7:0] W_MULT_SET  = 8'h3b;
  localparam logic [7:0] W_LBA28_L   = 8'h3c;
  localparam logic [7:0] W_LBA28_H   = 8'h3d;
  localparam logic [7:0] W_MDMA      = 8'h3f;
  localparam logic [7:0] W_PIO_ADV   = 8'h40;
  localparam logic [7:0] W_CYC_FIRST = 8'h41;
  localparam logic [7:0] W_CYC_LAST  = 8'h44;
  localparam logic [7:0] W_QDEPTH    = 8'h4b;
  localparam logic [7:0] W_LINK_CAP  = 8'h4c;
  localparam logic [7:0] W_LINK_SUP  = 8'h4e;
  localparam logic [7:0] W_LINK_EN   = 8'h4f;
  localparam logic [7:0] W_UDMA      = 8'h58;
  localparam logic [7:0] W_ERASE_T   = 8'h59;
  localparam logic [7:0] W_MPW_REV   = 8'h5c;
  localparam logic [7:0] W_LBA48_0   = 8'h64;
  localparam logic [7:0] W_LBA48_3   = 8'h67;
  localparam logic [7:0] W_RSV105    = 8'h69;
  localparam logic [7:0] W_SEC_STAT  = 8'h80;
  localparam logic [7:0] W_ALIGN     = 8'hd1;
  localparam logic [7:0] W_ROTATION  = 8'hd9;
  localparam logic [7:0] W_INTEGRITY = 8'hff;

  // ==========================================================
  // Fixed and reset word values
  localparam logic [15:0] V_GEN_CFG   = 16'h0040;
  localparam logic [15:0] V_CYL       = 16'h3fff;
  localparam logic [15:0] V_SPEC_CFG  = 16'hc837;
  localparam logic [15:0] V_HEAD      = 16'h0010;
  localparam logic [15:0] V_RET5      = 16'h0240;
  localparam logic [15:0] V_SPT       = 16'h003f;
  localparam logic [15:0] V_OBS22     = 16'h0004;
  localparam logic [15:0] V_CAPAB     = 16'h0f00;
  localparam logic [15:0] V_CAPAB2    = 16'h4000;
  localparam logic [15:0] V_PIO_OLD   = 16'h0200;
  localparam logic [15:0] V_VALID     = 16'h0007;
  localparam logic [15:0] V_MDMA_RST  = 16'h0007;
  localparam logic [15:0] V_PIO_ADV   = 16'h0003;
  localparam logic [15:0] V_CYCLE     = 16'h0078;
  localparam logic [15:0] V_QDEPTH    = 16'h001f;
  localparam logic [15:0] V_LINK_CAP  = 16'h0306;
  localparam logic [15:0] V_LINK_SUP  = 16'h0048;
  localparam logic [15:0] V_LINK_EN   = 16'h0040;
  localparam logic [15:0] V_UDMA_RST  = 16'h407f;
  localparam logic [15:0] V_ERASE_T   = 16'h0003;
  localparam logic [15:0] V_MPW_REV   = 16'hfffe;
  localparam logic [15:0] V_RSV105    = 16'h0100;
  localparam logic [15:0] V_SEC_RST   = 16'h0021;
  localparam logic [15:0] V_ALIGN     = 16'h4000;
  localparam logic [15:0] V_ROTATION  = 16'h0001;
  localparam logic [7:0]  V_SIGNATURE = 8'ha5;
  localparam logic [7:0]  V_SPACE     = 8'h20;
  localparam logic [7:0]  V_MULT_MAX  = 8'h01;
  localparam logic [7:0]  V_MULT_RST  = 8'h01;
  localparam logic [7:0]  V_MULT_TAG  = 8'h80;
  localparam logic [7:0]  V_MULT_VALID = 8'h01;

  // ==========================================================
  // Model string store
  localparam int unsigned MODEL_WORDS = 20;
  localparam int unsigned MODEL_AW    = 5;

endpackage

// file: design/model_store.sv
// Small rewritable store for the model-number words of the page.
// Assumes writes and reads come from the same clock; read data is registered.
`timescale 1ns/1ps
module model_store
  import id_page_pkg::*;
#(
  parameter int unsigned DEPTH = MODEL_WORDS,
  parameter int unsigned AW    = MODEL_AW
) (
  // Clock
  input  wire logic          clk,
  // Write side
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [15:0]   wr_data,
  // Read side
  input  wire logic [AW-1:0] rd_addr,
  output logic      [15:0]   rd_data
);

  logic [15:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule

// file: design/id_page_gen.sv
// Identify-device parameter page generator: streams 256 words on request.
// Assumes the command layer raises START for a single-sector data-in phase
// and drains words with ready/valid; settings inputs come from the same clock.
//
// Operation
// - Word 63 reports MDMA support and selection, reset 0007h, host may change selection.
// - Word 64 reads 0003h, PIO modes 3 and 4.
// - Words 65 to 68 each read 0078h cycle times.
// - Word 75 reads 001fh, queue depth minus one.
// - Word 76 reads 0306h serial-link capabilities.
// - Word 78 reads 0048h; word 79 enables, reset 0040h, host may change.
// - Word 88 reads 407Fh at reset; selection follows host transfer mode changes.
// - Word 89 reads erase time 0003h.
// - Word 92 reads master password revision FFFEh.
// - Words 100 to 103 hold the 48-bit user sector count.
// - Word 128 security status, reset 0021h, follows security state changes.
// - Word 209 reads 4000h alignment.
// - Word 217 reads 0001h, non-rotating media.
// - Word 2 reads C837h specific configuration.
// - Word 0 bit 6 set, non-removable device.
// - Model words 27 to 46 left-justified, padded with 20h spaces; the generator streams the model store as loaded and adds no padding.
// - Word 47 gives the maximum sectors per interrupt for multiple commands.
// - Word 49 bit 13 clear, bits 11, 10, 9, 8 set.
// - Word 51 bits 15 to 8 hold 02h.
// - Word 53 bits 0, 1, 2 flag words 54-58, 64-70, 88 valid.
// - Word 59 bits 15-9 zero, bit 8 valid, low byte current multiple setting.
// - Words 57-58 hold cylinders times heads times sectors per track.
// - Page leaves as one 256-word data-in block, like a single-sector read.
`timescale 1ns/1ps
module id_page_gen
  import id_page_pkg::*;
#(
  parameter logic [15:0] CUR_CYL   = V_CYL,
  parameter logic [15:0] CUR_HEADS = V_HEAD,
  parameter logic [15:0] CUR_SPT   = V_SPT
) (
  // Clock and reset
  input  wire logic        MCLK,
  input  wire logic        RSTN,
  // Capacity and geometry
  input  wire logic [47:0] USER_SECTORS,
  input  wire logic [31:0] LBA28_SECTORS,
  // Host setting changes, one-cycle strobes with data
  input  wire logic        MDMA_SET,
  input  wire logic [2:0]  MDMA_MODE,
  input  wire logic        UDMA_SET,
  input  wire logic [2:0]  UDMA_MODE,
  input  wire logic        LINK_EN_SET,
  input  wire logic [15:0] LINK_EN_VALUE,
  input  wire logic        MULT_SET,
  input  wire logic [7:0]  MULT_VALUE,
  input  wire logic        SEC_SET,
  input  wire logic [15:0] SEC_VALUE,
  // Model string loading
  input  wire logic        MODEL_WR,
  input  wire logic [4:0]  MODEL_ADDR,
  input  wire logic [15:0] MODEL_DATA,
  // Page stream
  input  wire logic        START,
  input  wire logic        OUT_READY,
  output logic             OUT_VALID,
  output logic [15:0]      OUT_DATA,
  output logic             OUT_LAST,
  output logic             BUSY
);

  // ==========================================================
  // Types
  typedef enum logic [1:0] {IDLE, FETCH, SEND} phase_type;

  typedef struct packed {
    phase_type   phase;
    logic [7:0]  idx;
    logic [7:0]  sum;
    logic [15:0] mdma;
    logic [15:0] udma;
    logic [15:0] link_en;
    logic [7:0]  mult;
    logic [15:0] sec;
    logic        valid;
    logic [15:0] data;
    logic        last;
    logic        busy;
  } state_type;

  state_type   state_reg;
  state_type   state_next;
  logic [15:0] model_word;
  logic [15:0] word_val;
  logic [31:0] cur_cap;
  logic [15:0] out_word;

  // ==========================================================
  // Functions
  function automatic logic [15:0] one_hot_sel(input logic [2:0] mode, input logic [7:0] supp);
    logic [7:0] sel;
    sel = 8'h01 << mode;
    return {sel, supp};
  endfunction

  function automatic logic [7:0] byte_sum(input logic [15:0] w);
    return w[15:8] + w[7:0];
  endfunction

  // ==========================================================
  // Model string store, read one cycle ahead of use. It is addressed by the
  // index about to be fetched, so that its registered word stands in FETCH.
  model_store #(
    .DEPTH (MODEL_WORDS),
    .AW    (MODEL_AW)
  ) u_model (
    .clk     (MCLK),
    .wr_en   (MODEL_WR),
    .wr_addr (MODEL_ADDR),
    .wr_data (MODEL_DATA),
    .rd_addr (MODEL_AW'(state_next.idx - W_MODEL_LO)),
    .rd_data (model_word)
  );

  // Fixed geometry, so the product folds to a constant
  assign cur_cap = 32'(CUR_CYL * CUR_HEADS * CUR_SPT);

  // ==========================================================
  // Word selection
  always_comb begin
    word_val = 16'h0000;
    case (state_reg.idx)
      W_GEN_CFG:   word_val = V_GEN_CFG;
      W_CYL_DEF:   word_val = V_CYL;
      W_SPEC_CFG:  word_val = V_SPEC_CFG;
      W_HEAD_DEF:  word_val = V_HEAD;
      W_RET5:      word_val = V_RET5;
      W_SPT_DEF:   word_val = V_SPT;
      W_OBS22:     word_val = V_OBS22;
      W_MULT_MAX:  word_val = {V_MULT_TAG, V_MULT_MAX};
      W_CAPAB:     word_val = V_CAPAB;
      W_CAPAB2:    word_val = V_CAPAB2;
      W_PIO_OLD:   word_val = V_PIO_OLD;
      W_VALID:     word_val = V_VALID;
      W_CUR_CYL:   word_val = CUR_CYL;
      W_CUR_HEAD:  word_val = CUR_HEADS;
      W_CUR_SPT:   word_val = CUR_SPT;
      W_CUR_CAP_L: word_val = cur_cap[15:0];
      W_CUR_CAP_H: word_val = cur_cap[31:16];
      W_MULT_SET:  word_val = {7'h00, V_MULT_VALID[0], state_reg.mult};
      W_LBA28_L:   word_val = LBA28_SECTORS[15:0];
      W_LBA28_H:   word_val = LBA28_SECTORS[31:16];
      W_MDMA:      word_val = state_reg.mdma;
      W_PIO_ADV:   word_val = V_PIO_ADV;
      W_QDEPTH:    word_val = V_QDEPTH;
      W_LINK_CAP:  word_val = V_LINK_CAP;
      W_LINK_SUP:  word_val = V_LINK_SUP;
      W_LINK_EN:   word_val = state_reg.link_en;
      W_UDMA:      word_val = state_reg.udma;
      W_ERASE_T:   word_val = V_ERASE_T;
      W_MPW_REV:   word_val = V_MPW_REV;
      W_RSV105:    word_val = V_RSV105;
      W_SEC_STAT:  word_val = state_reg.sec;
      W_ALIGN:     word_val = V_ALIGN;
      W_ROTATION:  word_val = V_ROTATION;
      default: begin
        if (state_reg.idx >= W_CYC_FIRST && state_reg.idx <= W_CYC_LAST) begin
          word_val = V_CYCLE;
        end else if (state_reg.idx >= W_LBA48_0 && state_reg.idx <= W_LBA48_3) begin
          word_val = USER_SECTORS[16*(state_reg.idx[1:0]) +: 16];
        end else if (state_reg.idx >= W_MODEL_LO && state_reg.idx < 8'(W_MODEL_LO + MODEL_WORDS)) begin
          word_val = model_word;
        end else begin
          word_val = 16'h0000;
        end
      end
    endcase
  end

  // Closing word carries the signature and the byte checksum
  always_comb begin
    out_word = word_val;
    if (state_reg.idx == W_INTEGRITY) begin
      out_word = {8'(8'h00 - state_reg.sum - V_SIGNATURE), V_SIGNATURE};
    end
  end

  // ==========================================================
  // Next state
  always_comb begin
    state_next = state_reg;

    // Settings are held stable while a page is in flight so the
    // checksum and the streamed words always agree.
    if (state_reg.phase == IDLE) begin
      if (MDMA_SET) begin
        state_next.mdma = one_hot_sel(MDMA_MODE, V_MDMA_RST[7:0]);
      end
      if (UDMA_SET) begin
        state_next.udma = one_hot_sel(UDMA_MODE, V_UDMA_RST[7:0]);
      end
      if (LINK_EN_SET) begin
        state_next.link_en = LINK_EN_VALUE & V_LINK_SUP;
      end
      if (MULT_SET) begin
        state_next.mult = MULT_VALUE;
      end
      if (SEC_SET) begin
        state_next.sec = SEC_VALUE;
      end
    end

    case (state_reg.phase)
      IDLE: begin
        state_next.valid = 1'b0;
        state_next.last  = 1'b0;
        if (START) begin
          state_next.phase = FETCH;
          state_next.idx   = 8'h00;
          state_next.sum   = 8'h00;
          state_next.busy  = 1'b1;
        end
      end
      FETCH: begin
        // One cycle lets the model store present its word
        state_next.phase = SEND;
        state_next.valid = 1'b1;
        state_next.data  = out_word;
        state_next.last  = (state_reg.idx == W_INTEGRITY);
        state_next.sum   = state_reg.sum + byte_sum(out_word);
      end
      SEND: begin
        if (OUT_READY) begin
          state_next.valid = 1'b0;
          state_next.last  = 1'b0;
          if (state_reg.last) begin
            state_next.phase = IDLE;
            state_next.busy  = 1'b0;
          end else begin
            state_next.phase = FETCH;
            state_next.idx   = state_reg.idx + 8'h01;
          end
        end
      end
      default: begin
        state_next.phase = IDLE;
      end
    endcase
  end

  // ==========================================================
  // State register
  always_ff @(posedge MCLK) begin
    if (!RSTN) begin
      state_reg.phase   <= IDLE;
      state_reg.idx     <= 8'h00;
      state_reg.sum     <= 8'h00;
      state_reg.mdma    <= V_MDMA_RST;
      state_reg.udma    <= V_UDMA_RST;
      state_reg.link_en <= V_LINK_EN;
      state_reg.mult    <= V_MULT_RST;
      state_reg.sec     <= V_SEC_RST;
      state_reg.valid   <= 1'b0;
      state_reg.data    <= 16'h0000;
      state_reg.last    <= 1'b0;
      state_reg.busy    <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign OUT_VALID = state_reg.valid;
  assign OUT_DATA  = state_reg.data;
  assign OUT_LAST  = state_reg.last;
  assign BUSY      = state_reg.busy;

endmodule

// file: verification/id_page_gen_monitor.sv
// Assertions on the page stream ports of the page generator.
// Assumes one clock and a synchronous active-low reset; bound below.
`timescale 1ns/1ps
module id_page_gen_monitor (
  // Clock and reset
  input wire logic        MCLK,
  input wire logic        RSTN,
  // Page stream
  input wire logic        START,
  input wire logic        OUT_READY,
  input wire logic        OUT_VALID,
  input wire logic [15:0] OUT_DATA,
  input wire logic        OUT_LAST,
  input wire logic        BUSY
);
  // ==========================================================
  // Word index and running byte sum of the page
  logic [7:0] idx_reg;
  logic [7:0] sum_reg;
  logic [7:0] sum_now;
  logic       take;
  assign take    = OUT_VALID && OUT_READY;
  assign sum_now = sum_reg + OUT_DATA[7:0] + OUT_DATA[15:8];
  always_ff @(posedge MCLK) begin
    if (!RSTN || (START && !BUSY)) begin
      idx_reg <= 8'h00;
      sum_reg <= 8'h00;
    end else if (take) begin
      idx_reg <= idx_reg + 8'h01;
      sum_reg <= sum_now;
    end
  end

  // ==========================================================
  // Properties
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RSTN);
  sequence s_accept;
    START && !BUSY;
  endsequence
  sequence s_launch;
    BUSY && !OUT_VALID ##1 OUT_VALID;
  endsequence
  sequence s_end;
    take && OUT_LAST;
  endsequence

  chk_start_launch: assert property (s_accept |=> s_launch)
    else $error("page did not start two cycles after start");
  chk_first_word: assert property (s_accept |-> ##2 OUT_DATA == 16'h0040)
    else $error("first word is not the general configuration");
  chk_hold_word: assert property (OUT_VALID && !OUT_READY |=> OUT_VALID && $stable(OUT_DATA) && $stable(OUT_LAST))
    else $error("offered word changed before it was taken");
  chk_word_gap: assert property (take && !OUT_LAST |=> !OUT_VALID ##1 OUT_VALID)
    else $error("next word not offered two cycles after handshake");
  chk_page_end: assert property (s_end |=> !BUSY && !OUT_VALID && !OUT_LAST)
    else $error("stream did not go idle after the last word");
  chk_last_flag: assert property (OUT_VALID |-> BUSY && (OUT_LAST == (idx_reg == 8'hff)))
    else $error("last flag not on word 255 alone");
  chk_page_sum: assert property (s_end |-> sum_now == 8'h00 && OUT_DATA[7:0] == 8'ha5)
    else $error("page bytes do not sum to zero or signature wrong");
  chk_spec_cfg: assert property (OUT_VALID && idx_reg == 8'h02 |-> OUT_DATA == 16'hc837)
    else $error("specific configuration word wrong");
  chk_queue_depth: assert property (OUT_VALID && idx_reg == 8'h4b |-> OUT_DATA == 16'h001f)
    else $error("queue depth word wrong");
endmodule

bind id_page_gen id_page_gen_monitor i_id_page_gen_monitor (
  .MCLK(MCLK), .RSTN(RSTN), .START(START), .OUT_READY(OUT_READY),
  .OUT_VALID(OUT_VALID), .OUT_DATA(OUT_DATA), .OUT_LAST(OUT_LAST), .BUSY(BUSY)
);

// file: verification/page_sink.sv
// Consumer model of the page stream: records words, may stall.
// Assumes the stream clock; ready moves on the falling edge.
`timescale 1ns/1ps
module page_sink (
  // Clock
  input wire logic        clk,
  // Bench control
  input wire logic        clr,
  input wire logic        stall,
  // Page stream
  input wire logic        valid,
  input wire logic [15:0] data,
  input wire logic        last,
  output logic            ready
);
  logic [15:0] words [0:255];
  int          count = 0;
  int          last_at = -1;
  logic [1:0]  cyc = 2'b00;
  initial ready = 1'b0;
  // Stalling keeps ready low three cycles in four to stress the hold
  always @(negedge clk) begin
    cyc   <= cyc + 2'b01;
    ready <= !stall || (cyc == 2'b11);
  end
  // One whole 256-word block taken per page, as for a sector read
  always @(posedge clk) begin
    if (clr) begin
      count   <= 0;
      last_at <= -1;
    end else if (valid && ready) begin
      if (count < 256) words[count] <= data;
      if (last) last_at <= count;
      count <= count + 1;
    end
  end
endmodule

// file: verification/tb.sv
// Self-checking bench for the parameter page generator.
// Assumes the sink model and the bound checker compile beside it.
`timescale 1ns/1ps
module tb;
  logic        mclk, rstn, start, out_ready, out_valid, out_last, busy, clr, stall;
  logic        mdma_set, udma_set, link_en_set, mult_set, sec_set, model_wr;
  logic [47:0] user_sectors;
  logic [31:0] lba28_sectors;
  logic [2:0]  mdma_mode, udma_mode;
  logic [15:0] link_en_value, sec_value, model_data, out_data;
  logic [7:0]  mult_value;
  logic [4:0]  model_addr;
  logic [15:0] exp_mdma, exp_udma, exp_link, exp_mult, exp_sec;
  logic [15:0] model [0:19];
  int          miscompares = 0;
  int          samples_checked = 0;

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  id_page_gen i_id_page_gen (.MCLK(mclk), .RSTN(rstn), .USER_SECTORS(user_sectors),
    .LBA28_SECTORS(lba28_sectors), .MDMA_SET(mdma_set), .MDMA_MODE(mdma_mode),
    .UDMA_SET(udma_set), .UDMA_MODE(udma_mode), .LINK_EN_SET(link_en_set),
    .LINK_EN_VALUE(link_en_value), .MULT_SET(mult_set), .MULT_VALUE(mult_value),
    .SEC_SET(sec_set), .SEC_VALUE(sec_value), .MODEL_WR(model_wr), .MODEL_ADDR(model_addr),
    .MODEL_DATA(model_data), .START(start), .OUT_READY(out_ready), .OUT_VALID(out_valid),
    .OUT_DATA(out_data), .OUT_LAST(out_last), .BUSY(busy));
  page_sink i_page_sink (.clk(mclk), .clr(clr), .stall(stall), .valid(out_valid),
    .data(out_data), .last(out_last), .ready(out_ready));

  // ==========================================================
  // Helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic set_defaults();
    exp_mdma = 16'h0007;
    exp_udma = 16'h407f;
    exp_link = 16'h0040;
    exp_mult = 16'h0101;
    exp_sec  = 16'h0021;
  endtask

  function automatic logic [15:0] exp_word(input int w);
    logic [31:0] cap;
    cap = 32'h3fff * 32'h0010 * 32'h003f;
    case (w)
      0: return 16'h0040;
      1, 54: return 16'h3fff;
      2: return 16'hc837;
      3, 55: return 16'h0010;
      5: return 16'h0240;
      6, 56: return 16'h003f;
      22: return 16'h0004;
      47: return 16'h8001;
      49: return 16'h0f00;
      50: return 16'h4000;
      51: return 16'h0200;
      53: return 16'h0007;
      57: return cap[15:0];
      58: return cap[31:16];
      59: return exp_mult;
      60: return lba28_sectors[15:0];
      61: return lba28_sectors[31:16];
      63: return exp_mdma;
      64: return 16'h0003;
      65, 66, 67, 68: return 16'h0078;
      75: return 16'h001f;
      76: return 16'h0306;
      78: return 16'h0048;
      79: return exp_link;
      88: return exp_udma;
      89: return 16'h0003;
      92: return 16'hfffe;
      100, 101, 102, 103: return user_sectors[16*(w-100) +: 16];
      105: return 16'h0100;
      128: return exp_sec;
      209: return 16'h4000;
      217: return 16'h0001;
      default: return (w >= 27 && w <= 46) ? model[w-27] : 16'h0000;
    endcase
  endfunction

  task automatic pulse(input logic [4:0] mask);
    @(negedge mclk);
    {mdma_set, udma_set, link_en_set, mult_set, sec_set} = mask;
    @(negedge mclk);
    {mdma_set, udma_set, link_en_set, mult_set, sec_set} = 5'b00000;
  endtask

  task automatic begin_page(input logic stall_on);
    @(negedge mclk);
    stall = stall_on;
    start = 1'b1;
    clr = 1'b1;
    @(negedge mclk);
    start = 1'b0;
    clr = 1'b0;
  endtask

  task automatic finish_page();
    logic [7:0]  sum;
    logic [15:0] e;
    int          n;
    sum = 8'h00;
    for (n = 0; n < 3000 && busy === 1'b1; n++) @(negedge mclk);
    chk(16'(i_page_sink.count), 16'h0100);
    chk(16'(i_page_sink.last_at), 16'h00ff);
    for (n = 0; n < 255; n++) begin
      e = exp_word(n);
      sum = sum + e[7:0] + e[15:8];
      chk(i_page_sink.words[n], e);
    end
    chk(i_page_sink.words[255], {8'h00 - sum - 8'ha5, 8'ha5});
  endtask

  task automatic run_page(input logic stall_on);
    begin_page(stall_on);
    finish_page();
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_defaults();
    run_page(1'b0);
  endtask

  task automatic t_modes();
    int m;
    for (m = 0; m < 7; m++) begin
      mdma_mode = 3'(m % 3);
      udma_mode = 3'(m);
      pulse(5'b11000);
      exp_mdma = {8'h01 << (m % 3), 8'h07};
      exp_udma = {8'h01 << m, 8'h7f};
      run_page(1'b0);
    end
  endtask

  task automatic t_settings();
    link_en_value = 16'hffff;
    mult_value = 8'h00;
    sec_value = 16'h0015;
    pulse(5'b00111);
    exp_link = 16'h0048;
    exp_mult = 16'h0100;
    exp_sec = 16'h0015;
    run_page(1'b1);
  endtask

  // Strobes during a page are dropped, not held for the next one
  task automatic t_refused();
    begin_page(1'b1);
    repeat (20) @(negedge mclk);
    mdma_mode = 3'd1;
    udma_mode = 3'd2;
    sec_value = 16'h0001;
    pulse(5'b11111);
    finish_page();
    run_page(1'b0);
  endtask

  task automatic t_reset_mid();
    begin_page(1'b1);
    repeat (100) @(negedge mclk);
    rstn = 1'b0;
    repeat (2) @(negedge mclk);
    chk({14'h0000, busy, out_valid}, 16'h0000);
    rstn = 1'b1;
    set_defaults();
    run_page(1'b1);
  endtask

  // ==========================================================
  // Main sequence and watchdog
  initial begin
    rstn = 1'b0;
    {start, clr, stall, model_wr, mdma_set, udma_set, link_en_set, mult_set, sec_set} = '0;
    {mdma_mode, udma_mode, mult_value, model_addr} = '0;
    {link_en_value, sec_value, model_data} = '0;
    user_sectors = 48'h0123_4567_89ab;
    lba28_sectors = 32'h0fed_cba9;
    set_defaults();
    repeat (16) @(negedge mclk);
    rstn = 1'b1;
    for (int i = 0; i < 20; i++) begin
      model[i] = (i < 3) ? 16'h4142 + 16'(i) : 16'h2020;
      @(negedge mclk);
      model_wr = 1'b1;
      model_addr = 5'(i);
      model_data = model[i];
    end
    @(negedge mclk);
    model_wr = 1'b0;
    t_defaults();
    t_modes();
    t_settings();
    t_refused();
    t_reset_mid();
    end_sim();
  end

  // Twelve pages at four cycles a word fit well inside this span
  initial begin
    repeat (60000) @(posedge mclk);
    miscompares++;
    end_sim();
  end
endmodule
